// file: src/rtcbk_consts.svh
`ifndef RTCBK_CONSTS_SVH
`define RTCBK_CONSTS_SVH
// clock source select codes
`define RTCBK_SRC_NONE 2'h0
`define RTCBK_SRC_XTAL 2'h1
`define RTCBK_SRC_RC 2'h2
`define RTCBK_SRC_FAST 2'h3
// fast clock divider, 128 edges give one enable
`define RTCBK_FAST_DIV 7'h7F
// prescaler reload: 32768 - 1 gives one second from 32.768 kHz
`define RTCBK_PRESC_DEF 20'h07FFF
// compare parks at all ones so a fresh counter does not alarm early
`define RTCBK_CMP_RST 32'hFFFFFFFF
// 512 Hz from 32.768 kHz: toggle every 32 source ticks
`define RTCBK_CAL_HALF 6'h1F
`define RTCBK_NUM_BKP 10
`define RTCBK_BKP_IDX_W 4
`endif

// file: src/rtcbk_pkg.sv
package rtcbk_pkg;
  typedef logic [15:0] rtcbk_word_t;
  typedef logic [1:0] rtcbk_src_t;
endpackage : rtcbk_pkg

// file: src/rtcbk_top.sv
`timescale 1ns/100ps
`include "rtcbk_consts.svh"
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1: ten 16-bit backup words hold user data while main power is absent.
// RL2: counters always run; alarm and periodic tick requests are separate. The code stops them when src_sel_i selects no source.
// RL3: source select: slow crystal, slow RC, or fast clock divided by 128.
// RL4: a 512 Hz calibration square wave is driven when enabled.
// RL5: 32-bit counter advances per tick; compare value raises alarm.
// RL6: 20-bit prescaler divides source; default reload gives one second.
// RL7: block keeps running in stop and standby low-power states.
// RL8: alarm request also drives a standby wakeup output.
// RL9: alarm set on the tick the counter equals compare; held until cleared.
module rtcbk_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // slow and fast clock sources, from pins
  input wire logic slow_external_crystal_i,
  input wire logic slow_internal_rc_i,
  input wire logic fast_external_clock_i,
  // configuration
  input wire logic [1:0] src_sel_i,
  input wire logic [19:0] presc_load_i,
  input wire logic presc_load_we_i,
  input wire logic [31:0] cnt_load_i,
  input wire logic cnt_load_we_i,
  input wire logic [31:0] cmp_i,
  input wire logic cmp_we_i,
  input wire logic cal_en_i,
  input wire logic low_power_i,
  // request clears
  input wire logic alarm_clr_i,
  input wire logic tick_clr_i,
  // backup store
  input wire logic bkp_we_i,
  input wire logic [3:0] bkp_idx_i,
  input wire logic [15:0] bkp_wdata_i,
  output logic [15:0] bkp_rdata_o,
  // status and requests
  output logic [31:0] cnt_o,
  output logic alarm_irq_o,
  output logic tick_irq_o,
  output logic wakeup_o,
  output logic cal_o
);
  logic [2:0] xt_sync_r, rc_sync_r, fx_sync_r;
  logic [6:0] fdiv_r;
  logic src_tick;
  logic [19:0] presc_rld_r, presc_r;
  logic tb_tick;
  logic [31:0] cmp_r;
  logic [5:0] cal_cnt_r;
  rtcbk_pkg::rtcbk_word_t bkp_mem [`RTCBK_NUM_BKP];
  logic fast_tick_r;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop sync plus edge stage, edge read from stages 1 and 2 only
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      xt_sync_r <= 3'h0;
      rc_sync_r <= 3'h0;
      fx_sync_r <= 3'h0;
    end else begin
      xt_sync_r <= {xt_sync_r[1:0], slow_external_crystal_i};
      rc_sync_r <= {rc_sync_r[1:0], slow_internal_rc_i};
      fx_sync_r <= {fx_sync_r[1:0], fast_external_clock_i};
    end
  end

  // fast source must stay below half of sys_clk to be sampled
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fdiv_r <= 7'h00;
      fast_tick_r <= 1'b0;
    end else begin
      fast_tick_r <= 1'b0;
      if (fx_sync_r[1] && !fx_sync_r[2]) begin
        fdiv_r <= fdiv_r + 7'h01;
        fast_tick_r <= (fdiv_r == `RTCBK_FAST_DIV); // [RL3]
      end
    end
  end

  always_comb begin
    src_tick = 1'b0;
    case (src_sel_i) // [RL3]
      `RTCBK_SRC_XTAL: src_tick = xt_sync_r[1] && !xt_sync_r[2];
      `RTCBK_SRC_RC: src_tick = rc_sync_r[1] && !rc_sync_r[2];
      `RTCBK_SRC_FAST: src_tick = fast_tick_r;
      default: src_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler; low_power_i deliberately unused by the time base [RL7]
  assign tb_tick = src_tick && (presc_r == 20'h00000);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      presc_rld_r <= `RTCBK_PRESC_DEF; // [RL6]
      presc_r <= `RTCBK_PRESC_DEF;
    end else begin
      if (presc_load_we_i) begin
        presc_rld_r <= presc_load_i;
        presc_r <= presc_load_i;
      end else if (src_tick) begin
        presc_r <= tb_tick ? presc_rld_r : presc_r - 20'h00001; // [RL6]
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_o <= 32'h00000000;
    end else if (cnt_load_we_i) begin
      cnt_o <= cnt_load_i;
    end else if (tb_tick) begin
      cnt_o <= cnt_o + 32'h00000001; // [RL5] [RL2]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cmp_r <= `RTCBK_CMP_RST;
    end else if (cmp_we_i) begin
      cmp_r <= cmp_i; // [RL5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // requests: set wins over clear
  logic alarm_set;
  assign alarm_set = tb_tick && !cnt_load_we_i &&
                     ((cnt_o + 32'h00000001) == cmp_r);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      alarm_irq_o <= 1'b0;
      tick_irq_o <= 1'b0;
      wakeup_o <= 1'b0;
    end else begin
      if (alarm_set) alarm_irq_o <= 1'b1; // [RL9]
      else if (alarm_clr_i) alarm_irq_o <= 1'b0;
      if (tb_tick) tick_irq_o <= 1'b1; // [RL2]
      else if (tick_clr_i) tick_irq_o <= 1'b0;
      if (alarm_set && low_power_i) wakeup_o <= 1'b1; // [RL8]
      else if (!low_power_i) wakeup_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calibration: exact 512 Hz only for a 32.768 kHz source
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cal_cnt_r <= 6'h00;
      cal_o <= 1'b0;
    end else if (!cal_en_i) begin
      cal_cnt_r <= 6'h00;
      cal_o <= 1'b0;
    end else if (src_tick) begin
      cal_cnt_r <= cal_cnt_r + 6'h01;
      if (cal_cnt_r == `RTCBK_CAL_HALF) begin
        cal_cnt_r <= 6'h00;
        cal_o <= !cal_o; // [RL4]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // backup store, not cleared by reset so contents survive it [RL1]
  function automatic logic bkp_idx_ok(input logic [3:0] idx);
    return idx < 4'(`RTCBK_NUM_BKP);
  endfunction : bkp_idx_ok

  always_ff @(posedge sys_clk_i) begin
    if (bkp_we_i && bkp_idx_ok(bkp_idx_i)) begin
      bkp_mem[bkp_idx_i] <= bkp_wdata_i; // [RL1]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bkp_rdata_o <= 16'h0000;
    end else if (bkp_idx_ok(bkp_idx_i)) begin
      bkp_rdata_o <= bkp_mem[bkp_idx_i];
    end else begin
      bkp_rdata_o <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_alarm_on_match: assert property ( // [RL9]
    @(posedge sys_clk_i) disable iff (srst_i)
    alarm_set |=> alarm_irq_o && (cnt_o == $past(cmp_r)))
    else $error("alarm not raised on match");
  chk_alarm_held: assert property ( // [RL9]
    @(posedge sys_clk_i) disable iff (srst_i)
    alarm_irq_o && !alarm_clr_i |=> alarm_irq_o)
    else $error("alarm dropped without clear");
  chk_alarm_cause: assert property ( // [RL5]
    @(posedge sys_clk_i) disable iff (srst_i)
    $rose(alarm_irq_o) |-> $past(tb_tick))
    else $error("alarm rose without tick");
  chk_cnt_step: assert property ( // [RL5]
    @(posedge sys_clk_i) disable iff (srst_i)
    tb_tick && !cnt_load_we_i |=> cnt_o == $past(cnt_o) + 32'h00000001)
    else $error("counter did not step");
  chk_cnt_hold: assert property ( // [RL2]
    @(posedge sys_clk_i) disable iff (srst_i)
    !tb_tick && !cnt_load_we_i |=> $stable(cnt_o))
    else $error("counter moved without tick");
  chk_tick_flag: assert property ( // [RL2]
    @(posedge sys_clk_i) disable iff (srst_i)
    tb_tick |=> tick_irq_o)
    else $error("periodic request missing");
  chk_presc_reload: assert property ( // [RL6]
    @(posedge sys_clk_i) disable iff (srst_i)
    tb_tick && !presc_load_we_i |=> presc_r == $past(presc_rld_r))
    else $error("prescaler did not reload");
  chk_wake_alarm: assert property ( // [RL8]
    @(posedge sys_clk_i) disable iff (srst_i)
    alarm_set && low_power_i |=> wakeup_o)
    else $error("no wakeup on alarm");
  chk_cal_idle: assert property ( // [RL4]
    @(posedge sys_clk_i) disable iff (srst_i)
    !cal_en_i |=> !cal_o)
    else $error("calibration output while off");
  chk_src_none: assert property ( // [RL3]
    @(posedge sys_clk_i) disable iff (srst_i)
    src_sel_i == `RTCBK_SRC_NONE |-> !tb_tick)
    else $error("tick with no source");
endmodule : rtcbk_top

// file: sim/rtcbk_src_model.sv
`timescale 1ns/100ps
module rtcbk_src_model (
  // source clocks
  output logic xtal_o,
  output logic rc_o,
  output logic fast_o
);
  // periods scaled down; whole sys cycles keep tick spacing exact
  initial begin
    xtal_o = 1'h0;
    #3;
    forever #250 xtal_o = ~xtal_o;
  end
  initial begin
    rc_o = 1'h0;
    #3;
    forever #350 rc_o = ~rc_o;
  end
  initial begin
    fast_o = 1'h0;
    #3;
    forever #50 fast_o = ~fast_o;
  end
endmodule : rtcbk_src_model

// file: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic sys_clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic xtal, rc, fast, pwe, cwe, kwe, cal_en, lp, aclr, tclr, bwe;
  logic [1:0] src = 2'h0;
  logic [19:0] presc = 20'h00003;
  logic [31:0] cld, cmp, cnt;
  logic [3:0] idx = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] rd;
  logic alarm, tick, wake, cal;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  int per [4] = '{32'h00001388, 32'h00000050, 32'h00000070, 32'h00000800};
  ////////////////////////////////////////////////////////////////////////
  always #12.5 sys_clk_i = ~sys_clk_i;
  rtcbk_src_model rtcbk_src_model_inst (.xtal_o(xtal), .rc_o(rc),
    .fast_o(fast));
  rtcbk_top rtcbk_top_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .slow_external_crystal_i(xtal), .slow_internal_rc_i(rc),
    .fast_external_clock_i(fast), .src_sel_i(src), .presc_load_i(presc),
    .presc_load_we_i(pwe), .cnt_load_i(cld), .cnt_load_we_i(cwe),
    .cmp_i(cmp), .cmp_we_i(kwe), .cal_en_i(cal_en), .low_power_i(lp),
    .alarm_clr_i(aclr), .tick_clr_i(tclr), .bkp_we_i(bwe),
    .bkp_idx_i(idx), .bkp_wdata_i(wd), .bkp_rdata_o(rd), .cnt_o(cnt),
    .alarm_irq_o(alarm), .tick_irq_o(tick), .wakeup_o(wake), .cal_o(cal));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #2;
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask : pulse
  // cycles until the counter or the calibration output changes
  task automatic wait_chg(input bit on_cal, output int k);
    logic [31:0] v;
    v = on_cal ? {31'h0, cal} : cnt;
    k = 0;
    while ((on_cal ? {31'h0, cal} : cnt) === v && k < 5000) begin
      cyc(1);
      k++;
    end
  endtask : wait_chg
  ////////////////////////////////////////////////////////////////////////
  task automatic t_bkp;
    for (int i = 0; i < 11; i++) begin
      idx = i[3:0];
      wd = 16'hA5A0 + i[15:0];
      bwe = 1'h1;
      cyc(1);
    end
    bwe = 1'h0;
    for (int i = 0; i < 11; i++) begin
      idx = i[3:0];
      cyc(2);
      chk("bkp", (i < 10) ? 32'hA5A0 + i : 32'h0, {16'h0, rd});
    end
  endtask : t_bkp
  task automatic t_alarm;
    lp = 1'h1;
    src = 2'h1;
    cld = 32'hFFFFFFFE;
    cmp = 32'h00000000;
    pulse(pwe);
    pulse(cwe);
    pulse(kwe);
    wait_chg(1'b0, n);
    chk("cnt", 32'hFFFFFFFF, cnt);
    chk("alarm", 32'h0, {31'h0, alarm});
    chk("tick", 32'h1, {31'h0, tick});
    wait_chg(1'b0, n);
    chk("period", 32'h00000050, n);
    chk("cnt", 32'h0, cnt);
    cyc(40);
    chk("alarm", 32'h1, {31'h0, alarm});
    chk("wakeup", 32'h1, {31'h0, wake});
    pulse(aclr);
    chk("alarm", 32'h0, {31'h0, alarm});
    pulse(tclr);
    chk("tick", 32'h0, {31'h0, tick});
    lp = 1'h0;
    cyc(1);
    chk("wakeup", 32'h0, {31'h0, wake});
  endtask : t_alarm
  // low-power state held on: the time base must not notice it
  task automatic t_src;
    lp = 1'h1;
    for (int s = 0; s < 4; s++) begin
      src = s[1:0];
      wait_chg(1'b0, n);
      wait_chg(1'b0, n);
      chk("src period", per[s], n);
    end
    lp = 1'h0;
  endtask : t_src
  task automatic t_cal;
    src = 2'h1;
    cal_en = 1'h1;
    wait_chg(1'b1, n);
    wait_chg(1'b1, n);
    chk("cal half", 32'h00000280, n);
  endtask : t_cal
  // mid-run reset: state clears, backup words must survive
  task automatic t_rst;
    srst_i = 1'h1;
    cyc(2);
    srst_i = 1'h0;
    idx = 4'h3;
    cyc(2);
    chk("cnt", 32'h0, cnt);
    chk("irqs", 32'h0, {29'h0, alarm, tick, wake});
    chk("bkp kept", 32'h0000A5A3, {16'h0, rd});
  endtask : t_rst
  ////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    {pwe, cwe, kwe, cal_en, lp, aclr, tclr, bwe} = 8'h00;
    cld = 32'h0;
    cmp = 32'h0;
    cyc(10);
    srst_i = 1'h0;
    chk("cnt", 32'h0, cnt);
    chk("irqs", 32'h0, {29'h0, alarm, tick, wake});
    chk("cal", 32'h0, {31'h0, cal});
    t_bkp();
    t_alarm();
    t_src();
    t_cal();
    t_rst();
    end_sim();
  end
endmodule : testbench
